// ==== hw/icr_defs.vh ====
// Constants for the two-wire master collision and rate generator block.
// Assumes inclusion by bare name from the block's single design file.
`ifndef ICR_DEFS_VH
`define ICR_DEFS_VH
// Register offsets on the plain register port
`define ICR_A_RELOAD    4'h0
`define ICR_A_BUFFER    4'h1
`define ICR_A_CTRL      4'h2
`define ICR_A_STATUS    4'h3
`define ICR_A_IRQ_FLAGS 4'h4
`define ICR_A_IRQ_MASK  4'h5
`define ICR_AW          4
// Sequence control bit positions
`define ICR_B_SEN       0
`define ICR_B_REPEATED_START_ENABLE      1
`define ICR_B_PEN       2
`define ICR_B_ACK_SEQUENCE_ENABLE     3
// Interrupt flag bit positions
`define ICR_B_COLL      0
`define ICR_B_EVT       1
// Reset values
`define ICR_RST_RELOAD  8'h13
`define ICR_RST_BYTE    8'h00
`define ICR_RST_CNT     8'h00
// Sequencer states
`define ICR_S_IDLE      4'h0
`define ICR_S_RS_REL    4'h1
`define ICR_S_RS_CNT1   4'h2
`define ICR_S_RS_SCLW   4'h3
`define ICR_S_RS_CNT2   4'h4
`define ICR_S_RS_CNT3   4'h5
`define ICR_S_P_SDAW    4'h6
`define ICR_S_P_SCLW    4'h7
`define ICR_S_P_CNT1    4'h8
`define ICR_S_P_CNT2    4'h9
`define ICR_S_P_CHK     4'hA
`define ICR_S_TX        4'hB
`endif

// ==== hw/icr_master.v ====
// Repeated Start / Stop sequencer with collision detection and rate counter.
// Assumes sda_i/scl_i come from open-drain pins outside the clk_sys domain.
//
// Our own choices: the register offsets and the plain strobed port.
`include "icr_defs.vh"

module icr_master #(
  parameter DW = 8
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire [3:0]    reg_addr,
  input  wire [DW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [DW-1:0] reg_rdata,
  input  wire          sda_i,
  output wire          sda_o,
  output wire          sda_oe,
  input  wire          scl_i,
  output wire          scl_o,
  output wire          scl_oe,
  output wire          irq
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Index 0 is SDA, index 1 is SCL
  localparam NPIN = 2;

  wire [NPIN-1:0] pin_raw = {scl_i, sda_i};
  wire [NPIN-1:0] pin_s;
  reg             scl_prev_q;
  wire            sda_s    = pin_s[0];
  wire            scl_s    = pin_s[1];
  wire            scl_fall = ~scl_s & scl_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      // Only the second stage is ever read by logic
      always @(posedge clk_sys) begin
        if (rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= pin_raw[gi];
          sync_q <= meta_q;
        end
      end
      assign pin_s[gi] = sync_q;
    end
  endgenerate

  // Idle level of SCL is high, so no false edge follows reset
  always @(posedge clk_sys) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  reg [DW-1:0] reload_q;
  reg [DW-1:0] buffer_q;
  reg [3:0]    seq_en_q;
  reg [1:0]    flags_q;
  reg [1:0]    mask_q;
  reg [3:0]    state_q;
  reg [3:0]    state_d;
  reg [DW-1:0] cnt_q;
  reg          cnt_run_q;
  reg          sda_drv_q;
  reg          scl_drv_q;
  reg          sda_drv_d;
  reg          scl_drv_d;
  reg          load_d;
  reg          stop_d;
  reg          coll_d;
  reg          done_d;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  localparam [3:0] S_IDLE    = `ICR_S_IDLE;
  localparam [3:0] S_RS_REL  = `ICR_S_RS_REL;
  localparam [3:0] S_RS_CNT1 = `ICR_S_RS_CNT1;
  localparam [3:0] S_RS_SCLW = `ICR_S_RS_SCLW;
  localparam [3:0] S_RS_CNT2 = `ICR_S_RS_CNT2;
  localparam [3:0] S_RS_CNT3 = `ICR_S_RS_CNT3;
  localparam [3:0] S_P_SDAW  = `ICR_S_P_SDAW;
  localparam [3:0] S_P_SCLW  = `ICR_S_P_SCLW;
  localparam [3:0] S_P_CNT1  = `ICR_S_P_CNT1;
  localparam [3:0] S_P_CNT2  = `ICR_S_P_CNT2;
  localparam [3:0] S_P_CHK   = `ICR_S_P_CHK;
  localparam [3:0] S_TX      = `ICR_S_TX;

  // ************************************************************
  // Address decode
  // ************************************************************
  function icr_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      icr_hit = (addr == target);
    end
  endfunction

  // Write-one-to-clear with set priority: an event in the
  // clearing cycle must not be lost.
  function [1:0] icr_w1c;
    input [1:0] cur;
    input [1:0] clr;
    input [1:0] set;
    begin
      icr_w1c = (cur & ~clr) | set;
    end
  endfunction

  wire wr_reload = reg_wr & icr_hit(reg_addr, `ICR_A_RELOAD);
  wire wr_buffer = reg_wr & icr_hit(reg_addr, `ICR_A_BUFFER);
  wire wr_ctrl   = reg_wr & icr_hit(reg_addr, `ICR_A_CTRL);
  wire wr_flags  = reg_wr & icr_hit(reg_addr, `ICR_A_IRQ_FLAGS);
  wire wr_mask   = reg_wr & icr_hit(reg_addr, `ICR_A_IRQ_MASK);
  wire idle      = (state_q == S_IDLE);
  wire expired   = cnt_run_q & (cnt_q == `ICR_RST_CNT);

  // ************************************************************
  // Rate counter
  // ************************************************************
  // Reload value 0..2 leaves too few cycles per half period.
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt_q     <= `ICR_RST_CNT;
      cnt_run_q <= 1'b0;
    end else if (coll_d | stop_d) begin
      cnt_run_q <= 1'b0;
    end else if (load_d) begin
      cnt_q     <= reload_q;
      cnt_run_q <= 1'b1;
    end else if (cnt_run_q & ~expired) begin
      cnt_q <= cnt_q - {{(DW-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @* begin
    state_d   = state_q;
    sda_drv_d = sda_drv_q;
    scl_drv_d = scl_drv_q;
    load_d    = 1'b0;
    stop_d    = 1'b0;
    coll_d    = 1'b0;
    done_d    = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (wr_ctrl & reg_wdata[`ICR_B_REPEATED_START_ENABLE]) begin
          sda_drv_d = 1'b0;
          state_d   = S_RS_REL;
        end else if (wr_ctrl & reg_wdata[`ICR_B_PEN]) begin
          sda_drv_d = 1'b1;
          state_d   = S_P_SDAW;
        end else if (wr_buffer) begin
          load_d  = 1'b1;
          state_d = S_TX;
        end
      end

      // Released SDA must float high before the first count
      S_RS_REL: begin
        if (sda_s) begin
          load_d  = 1'b1;
          state_d = S_RS_CNT1;
        end
      end

      S_RS_CNT1: begin
        if (expired) begin
          scl_drv_d = 1'b0;
          state_d   = S_RS_SCLW;
        end
      end

      // Level, not edge: SCL may already be high when released,
      // and a stretching slave may hold it low for a while.
      S_RS_SCLW: begin
        if (scl_s & ~sda_s) begin
          coll_d = 1'b1;
        end else if (scl_s) begin
          load_d  = 1'b1;
          state_d = S_RS_CNT2;
        end
      end

      // An SDA fall alone here is not flagged at once, but SDA still low at expiry is a loss
      S_RS_CNT2: begin
        if (scl_fall) begin
          coll_d = 1'b1;
        end else if (expired & ~sda_s) begin
          coll_d = 1'b1;
        end else if (expired) begin
          sda_drv_d = 1'b1;
          load_d    = 1'b1;
          state_d   = S_RS_CNT3;
        end
      end

      // SCL is pulled low whatever its level at expiry
      S_RS_CNT3: begin
        if (expired) begin
          scl_drv_d = 1'b1;
          stop_d    = 1'b1;
          done_d    = 1'b1;
          state_d   = S_IDLE;
        end
      end

      S_P_SDAW: begin
        if (~sda_s) begin
          scl_drv_d = 1'b0;
          state_d   = S_P_SCLW;
        end
      end

      // Waiting here is what allows clock stretching
      S_P_SCLW: begin
        if (scl_s) begin
          load_d  = 1'b1;
          state_d = S_P_CNT1;
        end
      end

      S_P_CNT1: begin
        if (~scl_s) begin
          coll_d = 1'b1;
        end else if (expired) begin
          sda_drv_d = 1'b0;
          load_d    = 1'b1;
          state_d   = S_P_CNT2;
        end
      end

      S_P_CNT2: begin
        if (~scl_s & ~sda_s) begin
          coll_d = 1'b1;
        end else if (expired) begin
          state_d = S_P_CHK;
        end
      end

      S_P_CHK: begin
        if (~sda_s) begin
          coll_d = 1'b1;
        end else begin
          stop_d  = 1'b1;
          done_d  = 1'b1;
          state_d = S_IDLE;
        end
      end

      S_TX: begin
        // Byte shifting lives elsewhere; only timing runs here.
        if (expired) begin
          stop_d  = 1'b1;
          done_d  = 1'b1;
          state_d = S_IDLE;
        end
      end

      default: begin
        state_d = S_IDLE;
      end
    endcase

    // Any loss of arbitration wins over the state's own plan
    if (coll_d) begin
      sda_drv_d = 1'b0;
      scl_drv_d = 1'b0;
      state_d   = S_IDLE;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= S_IDLE;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      sda_drv_q <= sda_drv_d;
      scl_drv_q <= scl_drv_d;
    end
  end

  // Open drain: only ever drive low; SCL hold-low persists after a repeated start is done.
  assign sda_o  = 1'b0;
  assign scl_o  = 1'b0;
  assign sda_oe = sda_drv_q;
  assign scl_oe = scl_drv_q;

  // ************************************************************
  // Register file and interrupts
  // ************************************************************
  // Reload values below three are not rejected; software must avoid them
  always @(posedge clk_sys) begin
    if (rst) begin
      reload_q <= `ICR_RST_RELOAD;
      buffer_q <= `ICR_RST_BYTE;
      mask_q   <= 2'h0;
    end else begin
      if (wr_reload) begin
        reload_q <= reg_wdata;
      end
      if (wr_buffer & idle) begin
        buffer_q <= reg_wdata;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[1:0];
      end
    end
  end

  // ************************************************************
  // Sequence enables and event flags
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      seq_en_q <= 4'h0;
      flags_q  <= 2'h0;
    end else begin
      if (coll_d | done_d) begin
        seq_en_q <= 4'h0;
      end else if (wr_ctrl & idle) begin
        seq_en_q <= reg_wdata[3:0];
      end
      flags_q <= icr_w1c(flags_q, {2{wr_flags}} & reg_wdata[1:0], {done_d, coll_d});
    end
  end

  assign irq = |(flags_q & mask_q);

  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= `ICR_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `ICR_A_RELOAD:    reg_rdata <= reload_q;
        `ICR_A_BUFFER:    reg_rdata <= buffer_q;
        `ICR_A_CTRL:      reg_rdata <= {{(DW-4){1'b0}}, seq_en_q};
        `ICR_A_STATUS:    reg_rdata <= {{(DW-6){1'b0}}, scl_s, sda_s, state_q};
        `ICR_A_IRQ_FLAGS: reg_rdata <= {{(DW-2){1'b0}}, flags_q};
        `ICR_A_IRQ_MASK:  reg_rdata <= {{(DW-2){1'b0}}, mask_q};
        default:          reg_rdata <= `ICR_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `ICR_RST_BYTE;
    end
  end

endmodule

// ==== testbench/icr_bus_model.sv ====
// Far side of the two-wire bus: pull-ups and another master.
// Assumes the bench drives the pull and link-clock requests.
module icr_bus_model (
  input  logic sda_oe,
  input  logic scl_oe,
  input  logic sda_pull,
  input  logic scl_pull,
  input  logic link_en,
  output logic sda,
  output logic scl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lclk = 1'b1;
  // Other master's clock; always runs, reaches SCL only while link_en is set
  initial begin
    #73;
    forever #200 lclk = ~lclk;
  end
  // Released lines float to the pull-up level
  assign sda = !(sda_oe || sda_pull);
  assign scl = !(scl_oe || scl_pull || (link_en && !lclk));
endmodule

// ==== testbench/icr_checker.sv ====
// Port checks of the repeated start and stop sequencer.
// Assumes sda_i and scl_i carry the wired bus levels.
`include "icr_defs.vh"
module icr_checker (
  input logic       clk_sys,
  input logic       rst,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       sda_i,
  input logic       sda_oe,
  input logic       scl_i,
  input logic       scl_oe,
  input logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rel_q;
  logic [7:0] msk_q;
  logic [8:0] sdo_q;
  logic [8:0] shi_q;
  logic [8:0] chi_q;
  // Saturating run lengths, so long idle spans cannot wrap
  always_ff @(posedge clk_sys) begin
    sdo_q <= !sda_oe ? 9'h000 : sdo_q + {8'h00, ~&sdo_q};
    shi_q <= (sda_oe || !sda_i) ? 9'h000 : shi_q + {8'h00, ~&shi_q};
    chi_q <= (scl_oe || !scl_i) ? 9'h000 : chi_q + {8'h00, ~&chi_q};
    if (rst) begin
      rel_q <= `ICR_RST_RELOAD;
      msk_q <= 8'h00;
    end else if (reg_wr && reg_addr == `ICR_A_RELOAD) begin
      rel_q <= reg_wdata;
    end else if (reg_wr && reg_addr == `ICR_A_IRQ_MASK) begin
      msk_q <= reg_wdata;
    end
  end
  // *********
  // Assertions
  // *********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($past(rst) |-> !sda_oe && !scl_oe && !irq)
    else $error("active after reset");
  a_rdata_gap: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  a_reload_read: assert property (
    $past(reg_rd && reg_addr == `ICR_A_RELOAD) |-> reg_rdata == $past(rel_q))
    else $error("reload value wrong");
  a_irq_masked: assert property (irq |-> msk_q != 8'h00 || $past(msk_q) != 8'h00)
    else $error("irq while masked");
  a_stop_release: assert property ($fell(scl_oe) && sda_oe |-> $past(!sda_i))
    else $error("clock released early");
  a_stop_count: assert property (
    $fell(sda_oe) && !scl_oe && scl_i && $past(scl_i) |-> chi_q >= {1'b0, rel_q})
    else $error("stop count short");
  a_rs_release: assert property ($fell(scl_oe) && !sda_oe |-> shi_q >= {1'b0, rel_q})
    else $error("restart count short");
  a_rs_drive: assert property ($rose(scl_oe) |-> sdo_q >= {1'b0, rel_q})
    else $error("clock driven early");
  c_rs_done: cover property ($rose(scl_oe));
  c_stop_done: cover property ($fell(sda_oe) && !scl_oe);
  c_irq: cover property ($rose(irq));
endmodule
bind icr_master icr_checker i_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sda_i(sda_i), .sda_oe(sda_oe), .scl_i(scl_i), .scl_oe(scl_oe), .irq(irq));

// ==== testbench/tb_icr_master.sv ====
// Bench for icr_master: registers, sequences and collisions.
// Assumes the bus model and the bound checker are compiled.
`include "icr_defs.vh"
module tb_icr_master;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys;
  logic        rst, reg_wr, reg_rd, sda_pull, scl_pull, link_en;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  wire         sda, scl, sda_oe, scl_oe, irq;
  int          err_count, comparisons;
  // Address, write data, read-back value; reload kept above the unusable values
  logic [19:0] rows [4] = '{{`ICR_A_RELOAD, 8'h05, 8'h05}, {`ICR_A_IRQ_MASK, 8'h03, 8'h03},
    {`ICR_A_STATUS, 8'hFF, 8'h30}, {4'hF, 8'hA5, 8'h00}};
  icr_master i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .irq(irq));
  icr_bus_model i_bus (.sda_oe(sda_oe), .scl_oe(scl_oe), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .link_en(link_en), .sda(sda), .scl(scl));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // *********
  // Tasks
  // *********
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic pins(input logic [7:0] e);
    repeat (2) @(negedge clk_sys);
    chk({5'h00, sda_oe, scl_oe, irq}, e);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded poll; a stuck sequencer ends the run
  task automatic idle();
    logic [7:0] s;
    repeat (300) begin
      rd(`ICR_A_STATUS, s);
      if (s[3:0] === 4'h0)
        return;
    end
    err_count++;
    $display("unexpected at %0t: sequencer stuck", $time);
    print_verdict();
  endtask
  task automatic outcome(input logic [7:0] f);
    idle();
    rd(`ICR_A_IRQ_FLAGS, d);
    chk(d, f);
    rd(`ICR_A_CTRL, d);
    chk(d, 8'h00);
    wr(`ICR_A_IRQ_FLAGS, 8'h03);
  endtask
  initial begin
    {rst, reg_wr, reg_rd, sda_pull, scl_pull, link_en} = 6'h20;
    {reg_addr, reg_wdata} = 12'h000;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`ICR_A_RELOAD, d);
    chk(d, `ICR_RST_RELOAD);
    pins(8'h00);
    foreach (rows[n]) begin
      wr(rows[n][19:16], rows[n][15:8]);
      rd(rows[n][19:16], d);
      chk(d, rows[n][7:0]);
    end
    $display("test registers done");
    wr(`ICR_A_BUFFER, 8'h5A);
    idle();
    pins(8'h01);
    wr(`ICR_A_IRQ_MASK, 8'h01);
    pins(8'h00);
    wr(`ICR_A_IRQ_MASK, 8'h03);
    wr(`ICR_A_IRQ_FLAGS, 8'h02);
    pins(8'h00);
    repeat (2) begin
      wr(`ICR_A_CTRL, 8'h02);
      outcome(8'h02);
    end
    pins(8'h06);
    wr(`ICR_A_CTRL, 8'h04);
    outcome(8'h02);
    $display("test sequences done");
    scl_pull <= 1'b1;
    wr(`ICR_A_CTRL, 8'h02);
    repeat (20) @(posedge clk_sys);
    sda_pull <= 1'b1;
    repeat (4) @(posedge clk_sys);
    scl_pull <= 1'b0;
    outcome(8'h01);
    pins(8'h00);
    sda_pull <= 1'b0;
    link_en <= 1'b1;
    wr(`ICR_A_CTRL, 8'h02);
    outcome(8'h01);
    wr(`ICR_A_CTRL, 8'h04);
    outcome(8'h01);
    link_en <= 1'b0;
    sda_pull <= 1'b1;
    wr(`ICR_A_CTRL, 8'h04);
    outcome(8'h01);
    sda_pull <= 1'b0;
    $display("test collisions done");
    print_verdict();
  end
endmodule
